// file: link_pkg.sv
// Notes on behaviour
// - Send only K28.5 during code group sync
// - Sync request held keeps commas until boundary
// - Alignment sequence starts at next multiframe boundary
// - Four alignment multiframes, each R first, A last
// - First alignment multiframe carries ramp after R
// - Second multiframe: R, Q, 14 config octets, A
// - Undefined alignment slots carry ramp data
// - Alignment sequence is never scrambled
// - Third and fourth multiframes repeat the first
// - Many config fields hold value minus one
// - Stream data after alignment; scrambling on by default
// - Scrambled frame end 0xFC becomes F
// - Scrambled multiframe end 0x7C becomes A
// - Unscrambled repeated frame end becomes A or F
// - Alignment insertion on by default, switchable
// - 8b/10b keeps line DC balanced, inserts controls
// - Encoder bypass, invert and mirror options
// - Lane outputs powered after reset
// - Control characters are K28.0/.3/.4/.5/.7
package link_pkg;

    localparam int OCT_PER_FRAME = 4;
    localparam int FRM_W         = 2;
    localparam int FRAMES_PER_MF = 32;
    localparam int MF_OCTETS     = OCT_PER_FRAME * FRAMES_PER_MF;
    localparam int POS_W         = 7;
    localparam int ILAS_MFS      = 4;
    localparam int ILAS_CYCLES   = ILAS_MFS * MF_OCTETS;
    localparam int CFG_FIRST     = 2;
    localparam int CFG_COUNT     = 14;
    localparam int SYNC_STAGES   = 3;

    localparam logic [7:0] CH_R = 8'h1C;
    localparam logic [7:0] CH_A = 8'h7C;
    localparam logic [7:0] CH_Q = 8'h9C;
    localparam logic [7:0] CH_K = 8'hBC;
    localparam logic [7:0] CH_F = 8'hFC;

    // Link parameters as sent in the configuration octets
    localparam int CFG_L        = 1;
    localparam int CFG_M        = 1;
    localparam int CFG_N        = 12;
    localparam int CFG_NP       = 16;
    localparam int CFG_S        = 4;
    localparam int CFG_CS       = 0;
    localparam int CFG_CF       = 0;
    localparam int CFG_HD       = 0;
    localparam int CFG_SUBCLASS = 1;
    localparam int CFG_JESDV    = 1;
    // Arbitrary identity values
    localparam logic [7:0] CFG_DEV_ID  = 8'h5A;
    localparam logic [7:0] CFG_BANK_ID = 8'h00;
    localparam logic [7:0] CFG_LANE_ID = 8'h00;

    localparam logic [14:0] SCR_SEED  = 15'h7FFF;
    localparam logic [1:0]  PIN_RESET = 2'h0;

    typedef enum logic [1:0] {
        ST_CGS  = 2'b00,
        ST_ILAS = 2'b01,
        ST_DATA = 2'b10
    } phase_t;

endpackage : link_pkg

// file: enc_8b10b.sv
`timescale 1ns/1ps
module enc_8b10b (
    input  wire logic       clock,    // 40 MHz clock
    input  wire logic       rstn,     // Sync reset, active low
    input  wire logic [7:0] octet,    // Octet to encode
    input  wire logic       is_k,     // Octet is a control character
    input  wire logic       bypass,   // Send raw octet
    input  wire logic       invert,   // Invert all bits
    input  wire logic       mirror,   // Reverse bit order
    output logic      [9:0] code_out  // Registered character, bit 9 first
);

    logic       rd_r;
    logic       rd_nxt;
    logic [9:0] code_r;
    logic [9:0] code_nxt;
    logic [9:0] raw10;
    logic [5:0] d6;
    logic [3:0] d4;
    logic       bal6;
    logic       bal4;
    logic       rd_mid;
    logic [4:0] x5;

    function automatic logic [5:0] tab6(input logic [4:0] x);
        case (x)
            5'd0:    tab6 = 6'b100111;
            5'd1:    tab6 = 6'b011101;
            5'd2:    tab6 = 6'b101101;
            5'd3:    tab6 = 6'b110001;
            5'd4:    tab6 = 6'b110101;
            5'd5:    tab6 = 6'b101001;
            5'd6:    tab6 = 6'b011001;
            5'd7:    tab6 = 6'b111000;
            5'd8:    tab6 = 6'b111001;
            5'd9:    tab6 = 6'b100101;
            5'd10:   tab6 = 6'b010101;
            5'd11:   tab6 = 6'b110100;
            5'd12:   tab6 = 6'b001101;
            5'd13:   tab6 = 6'b101100;
            5'd14:   tab6 = 6'b011100;
            5'd15:   tab6 = 6'b010111;
            5'd16:   tab6 = 6'b011011;
            5'd17:   tab6 = 6'b100011;
            5'd18:   tab6 = 6'b010011;
            5'd19:   tab6 = 6'b110010;
            5'd20:   tab6 = 6'b001011;
            5'd21:   tab6 = 6'b101010;
            5'd22:   tab6 = 6'b011010;
            5'd23:   tab6 = 6'b111010;
            5'd24:   tab6 = 6'b110011;
            5'd25:   tab6 = 6'b100110;
            5'd26:   tab6 = 6'b010110;
            5'd27:   tab6 = 6'b110110;
            5'd28:   tab6 = 6'b001110;
            5'd29:   tab6 = 6'b101110;
            5'd30:   tab6 = 6'b011110;
            default: tab6 = 6'b101011;
        endcase
    endfunction : tab6

    function automatic logic [3:0] tab4(input logic [2:0] y, input logic k);
        case (y)
            3'd0:    tab4 = 4'b1011;
            3'd1:    tab4 = k ? 4'b0110 : 4'b1001;
            3'd2:    tab4 = k ? 4'b1010 : 4'b0101;
            3'd3:    tab4 = 4'b1100;
            3'd4:    tab4 = 4'b1101;
            3'd5:    tab4 = k ? 4'b0101 : 4'b1010;
            3'd6:    tab4 = k ? 4'b1001 : 4'b0110;
            default: tab4 = k ? 4'b0111 : 4'b1110;
        endcase
    endfunction : tab4

    always_comb
    begin
        x5     = octet[4:0];
        d6     = is_k ? 6'b001111 : tab6(x5);
        bal6   = ($countones(d6) == 3);
        if (rd_r && (!bal6 || (!is_k && x5 == 5'd7)))
            d6 = ~d6;
        rd_mid = rd_r ^ !bal6;
        d4     = tab4(octet[7:5], is_k);
        if (!is_k && octet[7:5] == 3'd7 &&
            ((!rd_mid && (x5 == 5'd17 || x5 == 5'd18 || x5 == 5'd20)) ||
             (rd_mid && (x5 == 5'd11 || x5 == 5'd13 || x5 == 5'd14))))
            d4 = 4'b0111;
        bal4   = ($countones(d4) == 2);
        if (rd_mid && (is_k || !bal4 || octet[7:5] == 3'd3))
            d4 = ~d4;
        raw10  = {d6, d4};
        rd_nxt = bypass ? rd_r : (rd_mid ^ !bal4);
        code_nxt = bypass ? {2'b00, octet} : raw10;
        if (invert)
            code_nxt = ~code_nxt;
        if (mirror)
            code_nxt = {<<{code_nxt}};
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            rd_r   <= 1'b0;
            code_r <= 10'h000;
        end
        else
        begin
            rd_r   <= rd_nxt;
            code_r <= code_nxt;
        end
    end

    assign code_out = code_r;

    dc_balance_a: assert property (@(posedge clock) disable iff (!rstn)
        $countones(raw10) inside {4, 5, 6})
        else $error("Character disparity out of range");

    rd_flip_a: assert property (@(posedge clock) disable iff (!rstn)
        (!bypass && $countones(raw10) != 5) |=> (rd_r != $past(rd_r)))
        else $error("Running disparity did not follow character");

endmodule : enc_8b10b

// file: tx_link.sv
`timescale 1ns/1ps
module tx_link (
    input  wire logic       clock,            // 40 MHz clock
    input  wire logic       rstn,             // Sync reset, active low
    input  wire logic       sync_request_n,   // Receiver sync request pin, low active
    input  wire logic       sysref,           // System reference pin
    input  wire logic [7:0] data_in,          // User octet from transport
    output logic            data_take,        // Octet on data_in consumed
    input  wire logic       link_reset,       // Hold link in code group sync
    input  wire logic       scramble_off,     // Disable data scrambling
    input  wire logic       align_insert_off, // Disable alignment insertion
    input  wire logic       enc_bypass,       // Encoder bypass
    input  wire logic       enc_invert,       // Encoder output invert
    input  wire logic       enc_mirror,       // Encoder output mirror
    input  wire logic       lane_disable,     // Power lane down
    output logic            lane_on,          // Lane driver powered
    output logic      [9:0] lane_data,        // Encoded character
    output logic      [1:0] phase             // Current link phase
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    localparam int NPIN        = 2;
    localparam int SYNC_STAGES = link_pkg::SYNC_STAGES;

    logic [NPIN-1:0]        pin_in;
    logic [SYNC_STAGES-1:0] sh_r    [NPIN];
    logic [SYNC_STAGES-1:0] sh_nxt  [NPIN];
    logic                   lvl_r   [NPIN];
    logic                   lvl_nxt [NPIN];
    logic                   sync_ok;
    logic                   sysref_edge;


    assign pin_in = {sysref, sync_request_n};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_pin
            always_comb
            begin
                sh_nxt[gi]  = {sh_r[gi][SYNC_STAGES-2:0], pin_in[gi]};
                lvl_nxt[gi] = (sh_r[gi][1] == sh_r[gi][2]) ? sh_r[gi][2] : lvl_r[gi];
            end

            always_ff @(posedge clock)
            begin
                if (!rstn)
                begin
                    sh_r[gi]  <= '0;
                    lvl_r[gi] <= link_pkg::PIN_RESET[gi];
                end
                else
                begin
                    sh_r[gi]  <= sh_nxt[gi];
                    lvl_r[gi] <= lvl_nxt[gi];
                end
            end
        end
    endgenerate

    assign sync_ok     = lvl_r[0];
    assign sysref_edge = lvl_nxt[1] & ~lvl_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // Phase and multiframe position

    localparam logic [6:0] MF_LAST  = 7'(link_pkg::MF_OCTETS - 1);
    localparam logic [1:0] ILAS_END = 2'(link_pkg::ILAS_MFS - 1);

    link_pkg::phase_t state_r;
    link_pkg::phase_t state_nxt;
    logic [6:0]       pos_r;
    logic [6:0]       pos_nxt;
    logic [1:0]       mf_r;
    logic [1:0]       mf_nxt;
    logic             mf_end;
    logic             frame_end;

    assign mf_end    = (pos_r == MF_LAST);
    assign frame_end = (pos_r[link_pkg::FRM_W-1:0] == {link_pkg::FRM_W{1'b1}});

    always_comb
    begin
        state_nxt = state_r;
        mf_nxt    = mf_r;
        pos_nxt   = sysref_edge ? 7'h00 : 7'(pos_r + 7'h01);
        case (state_r)
            link_pkg::ST_CGS:
                if (sync_ok && mf_end)
                begin
                    state_nxt = link_pkg::ST_ILAS;
                    mf_nxt    = 2'h0;
                end
            link_pkg::ST_ILAS:
                if (!sync_ok)
                    state_nxt = link_pkg::ST_CGS;
                else if (mf_end)
                begin
                    if (mf_r == ILAS_END)
                        state_nxt = link_pkg::ST_DATA;
                    else
                        mf_nxt = 2'(mf_r + 2'h1);
                end
            link_pkg::ST_DATA:
                if (!sync_ok)
                    state_nxt = link_pkg::ST_CGS;
            default:
                state_nxt = link_pkg::ST_CGS;
        endcase
        if (link_reset)
            state_nxt = link_pkg::ST_CGS;
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            state_r <= link_pkg::ST_CGS;
            pos_r   <= 7'h00;
            mf_r    <= 2'h0;
        end
        else
        begin
            state_r <= state_nxt;
            pos_r   <= pos_nxt;
            mf_r    <= mf_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration octets

    function automatic logic [7:0] cfg_field(input logic [3:0] idx, input logic scr);
        case (idx)
            4'd0:    cfg_field = link_pkg::CFG_DEV_ID;
            4'd1:    cfg_field = link_pkg::CFG_BANK_ID;
            4'd2:    cfg_field = link_pkg::CFG_LANE_ID;
            4'd3:    cfg_field = {scr, 2'b00, 5'(link_pkg::CFG_L - 1)};
            4'd4:    cfg_field = 8'(link_pkg::OCT_PER_FRAME - 1);
            4'd5:    cfg_field = {3'b000, 5'(link_pkg::FRAMES_PER_MF - 1)};
            4'd6:    cfg_field = 8'(link_pkg::CFG_M - 1);
            4'd7:    cfg_field = {2'(link_pkg::CFG_CS), 1'b0, 5'(link_pkg::CFG_N - 1)};
            4'd8:    cfg_field = {3'(link_pkg::CFG_SUBCLASS), 5'(link_pkg::CFG_NP - 1)};
            4'd9:    cfg_field = {3'(link_pkg::CFG_JESDV), 5'(link_pkg::CFG_S - 1)};
            4'd10:   cfg_field = {1'(link_pkg::CFG_HD), 2'b00, 5'(link_pkg::CFG_CF)};
            default: cfg_field = 8'h00;
        endcase
    endfunction : cfg_field

    logic [7:0] fchk;
    logic [3:0] cfg_idx;
    logic       cfg_slot;

    always_comb
    begin
        fchk = 8'h00;
        for (int i = 0; i < link_pkg::CFG_COUNT - 1; i++)
            fchk = 8'(fchk + cfg_field(4'(i), !scramble_off));
    end

    assign cfg_idx  = 4'(pos_r - 7'(link_pkg::CFG_FIRST));
    assign cfg_slot = (mf_r == 2'h1) && (pos_r >= 7'(link_pkg::CFG_FIRST)) &&
                      (pos_r < 7'(link_pkg::CFG_FIRST + link_pkg::CFG_COUNT));

    ////////////////////////////////////////////////////////////////////////////
    // Character selection, scrambler and alignment substitution

    logic [14:0] scr_r;
    logic [14:0] scr_nxt;
    logic [14:0] scr_st;
    logic [7:0]  prev_r;
    logic [7:0]  prev_nxt;
    logic [7:0]  link_oct;
    logic [7:0]  enc_oct;
    logic        enc_k;
    logic        lane_on_r;

    always_comb
    begin
        scr_st   = scr_r;
        for (int b = 7; b >= 0; b--)
        begin
            link_oct[b] = data_in[b] ^ scr_st[14] ^ scr_st[13];
            scr_st      = {scr_st[13:0], link_oct[b]};
        end
        if (scramble_off)
            link_oct = data_in;
        scr_nxt  = scr_r;
        prev_nxt = prev_r;
        enc_k    = 1'b1;
        enc_oct  = link_pkg::CH_K;
        case (state_r)
            link_pkg::ST_ILAS:
            begin
                enc_k   = 1'b0;
                enc_oct = {1'b0, pos_r};
                if (pos_r == 7'h00)
                begin
                    enc_k   = 1'b1;
                    enc_oct = link_pkg::CH_R;
                end
                else if (mf_end)
                begin
                    enc_k   = 1'b1;
                    enc_oct = link_pkg::CH_A;
                end
                else if (mf_r == 2'h1 && pos_r == 7'h01)
                begin
                    enc_k   = 1'b1;
                    enc_oct = link_pkg::CH_Q;
                end
                else if (cfg_slot)
                    enc_oct = (cfg_idx == 4'(link_pkg::CFG_COUNT - 1)) ?
                              fchk : cfg_field(cfg_idx, !scramble_off);
            end
            link_pkg::ST_DATA:
            begin
                enc_k   = 1'b0;
                enc_oct = link_oct;
                if (!scramble_off)
                    scr_nxt = scr_st;
                if (frame_end)
                    prev_nxt = link_oct;
                if (!align_insert_off && frame_end)
                begin
                    if (!scramble_off)
                    begin
                        if (mf_end && link_oct == link_pkg::CH_A)
                            enc_k = 1'b1;
                        else if (link_oct == link_pkg::CH_F)
                            enc_k = 1'b1;
                    end
                    else if (link_oct == prev_r)
                    begin
                        enc_k   = 1'b1;
                        enc_oct = mf_end ? link_pkg::CH_A : link_pkg::CH_F;
                    end
                end
            end
            default:
            begin
                enc_k   = 1'b1;
                enc_oct = link_pkg::CH_K;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            scr_r     <= link_pkg::SCR_SEED;
            prev_r    <= 8'h00;
            lane_on_r <= 1'b1;
        end
        else
        begin
            scr_r     <= scr_nxt;
            prev_r    <= prev_nxt;
            lane_on_r <= !lane_disable;
        end
    end

    assign data_take = (state_r == link_pkg::ST_DATA);
    assign lane_on   = lane_on_r;
    assign phase     = state_r;

    enc_8b10b u_enc (
        .clock    (clock),
        .rstn     (rstn),
        .octet    (enc_oct),
        .is_k     (enc_k),
        .bypass   (enc_bypass),
        .invert   (enc_invert),
        .mirror   (enc_mirror),
        .code_out (lane_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [9:0] ilas_cnt_r;

    always_ff @(posedge clock)
    begin
        if (!rstn || state_r != link_pkg::ST_ILAS)
            ilas_cnt_r <= 10'h000;
        else
            ilas_cnt_r <= 10'(ilas_cnt_r + 10'h001);
    end

    cgs_comma_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == link_pkg::ST_CGS) |-> (enc_k && enc_oct == link_pkg::CH_K))
        else $error("Non-comma sent during code group sync");

    ilas_start_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == link_pkg::ST_CGS && sync_ok && mf_end && !link_reset && !sysref_edge)
        |=> (state_r == link_pkg::ST_ILAS && pos_r == 7'h00))
        else $error("Alignment sequence not started at boundary");

    ilas_len_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == link_pkg::ST_DATA && $past(state_r) == link_pkg::ST_ILAS)
        |-> ($past(ilas_cnt_r) == 10'(link_pkg::ILAS_CYCLES - 1)))
        else $error("Alignment sequence length wrong");

    ilas_ends_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == link_pkg::ST_ILAS && (pos_r == 7'h00 || mf_end))
        |-> (enc_k && enc_oct == (mf_end ? link_pkg::CH_A : link_pkg::CH_R)))
        else $error("Multiframe start or end character wrong");

    ilas_q_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == link_pkg::ST_ILAS && mf_r == 2'h1 && pos_r == 7'h01)
        |-> (enc_k && enc_oct == link_pkg::CH_Q))
        else $error("Link configuration marker missing");

    ilas_ramp_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == link_pkg::ST_ILAS && !enc_k && !cfg_slot)
        |-> (enc_oct == {1'b0, pos_r}))
        else $error("Alignment filler is not ramp");

    scr_f_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == link_pkg::ST_DATA && !scramble_off && !align_insert_off &&
         frame_end && !mf_end && link_oct == link_pkg::CH_F) |-> enc_k)
        else $error("Frame alignment character not inserted");

    nscr_rep_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == link_pkg::ST_DATA && scramble_off && !align_insert_off &&
         frame_end && link_oct == prev_r)
        |-> (enc_k && enc_oct == (mf_end ? link_pkg::CH_A : link_pkg::CH_F)))
        else $error("Repeated frame end not replaced");

    resync_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_r != link_pkg::ST_CGS && !sync_ok) |=> (state_r == link_pkg::ST_CGS))
        else $error("Sync request did not return to commas");

    lane_pwr_a: assert property (@(posedge clock)
        $rose(rstn) |-> lane_on)
        else $error("Lane not powered after reset");

    ilas_seen_c: cover property (@(posedge clock) disable iff (!rstn)
        state_r == link_pkg::ST_ILAS && mf_r == 2'h3 && mf_end);
    data_seen_c: cover property (@(posedge clock) disable iff (!rstn)
        $rose(state_r == link_pkg::ST_DATA));
    f_insert_c: cover property (@(posedge clock) disable iff (!rstn)
        state_r == link_pkg::ST_DATA && enc_k && enc_oct == link_pkg::CH_F);
    a_insert_c: cover property (@(posedge clock) disable iff (!rstn)
        state_r == link_pkg::ST_DATA && enc_k && enc_oct == link_pkg::CH_A);

endmodule : tx_link

// file: rx_model.sv
`timescale 1ns/1ps
module rx_model (
    input  wire logic       clock,                 // Link clock
    input  wire logic       rstn,                  // Sync reset, active low
    input  wire logic [9:0] lane_data,             // Received character
    input  wire logic       resync,                // Hold or start a sync request
    output logic            sync_request_n = 1'b0  // Sync request, low active
);
    logic [5:0] good_r = 6'h00;
    logic [5:0] hold_r = 6'h00;
    logic       is_k;

    assign is_k = lane_data == 10'h0FA || lane_data == 10'h305 || lane_data == 10'h0BC;

    always @(posedge clock)
    begin
        if (!rstn || resync)
        begin
            sync_request_n <= 1'b0;
            good_r         <= 6'h00;
            hold_r         <= 6'h14;
        end
        else if (hold_r != 6'h00)
            hold_r <= hold_r - 6'h01;
        else if (!sync_request_n)
        begin
            good_r <= is_k ? good_r + 6'h01 : 6'h00;
            if (good_r >= 6'h04)
                sync_request_n <= 1'b1;
        end
    end
endmodule : rx_model

// file: tb_tx_link.sv
`timescale 1ns/1ps
module tb_tx_link;
    logic       clock = 1'b0, rstn = 1'b0, resync = 1'b1, sync_request_n, data_take, lane_on;
    logic       enc_bypass = 1'b0, enc_invert = 1'b0, enc_mirror = 1'b0, lane_disable = 1'b0;
    logic       scr_off = 1'b1, ins_off = 1'b0, link_reset = 1'b0;
    logic [14:0] sr = link_pkg::SCR_SEED;
    logic [7:0] data_in = 8'h00, o, nx, last = 8'h00;
    logic [9:0] lane_data, v, prv;
    logic [1:0] phase, ph_q = 2'h0;
    logic [9:0] exp_q [$];
    int         fail_count = 0, checked = 0, cycles = 0, n = 0;

    always #12.5 clock = ~clock;

    tx_link uut (.clock(clock), .rstn(rstn), .sync_request_n(sync_request_n), .sysref(1'b0),
        .data_in(data_in), .data_take(data_take), .link_reset(link_reset), .scramble_off(scr_off),
        .align_insert_off(ins_off), .enc_bypass(enc_bypass), .enc_invert(enc_invert),
        .enc_mirror(enc_mirror), .lane_disable(lane_disable), .lane_on(lane_on),
        .lane_data(lane_data), .phase(phase));
    rx_model rx (.clock(clock), .rstn(rstn), .lane_data(lane_data), .resync(resync),
        .sync_request_n(sync_request_n));

    task automatic check(input string nm, input logic [9:0] s, input logic [9:0] e);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic stop_test;
        if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic wait_ph(input logic [1:0] p);
        int t = 0;
        while (phase !== p && t < 700)
        begin
            @(posedge clock);
            t++;
        end
        check("phase", {8'h00, phase}, {8'h00, p});
    endtask : wait_ph

    task automatic push_ilas(input logic s);
        logic [7:0] c [14];
        c = '{link_pkg::CFG_DEV_ID, 8'h00, 8'h00, {s, 7'h00}, 8'(link_pkg::OCT_PER_FRAME - 1),
              8'(link_pkg::FRAMES_PER_MF - 1), 8'h00, 8'(link_pkg::CFG_N - 1),
              8'h20 | 8'(link_pkg::CFG_NP - 1), 8'h20 | 8'(link_pkg::CFG_S - 1),
              8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 13; i++)
            c[13] += c[i];
        for (int i = 0; i < 512; i++)
        begin
            o = 8'(i % 128);
            if (i % 128 == 0)
                o = link_pkg::CH_R;
            else if (i % 128 == 127)
                o = link_pkg::CH_A;
            else if (i == 129)
                o = link_pkg::CH_Q;
            else if (i >= 130 && i < 144)
                o = c[i - 130];
            exp_q.push_back({2'b00, o});
        end
    endtask : push_ilas

    ////////////////////////////////////////////////////////////////
    // Stream driver notes each expected data-phase character
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fail_count++;
            stop_test();
        end
        if (data_take !== 1'b1)
        begin
            n = 0;
            data_in <= 8'($urandom);
            {enc_invert, enc_mirror} <= 2'b00;
        end
        else
        begin
            o = data_in;
            if (!scr_off)
                for (int b = 7; b >= 0; b--)
                begin
                    o[b] = data_in[b] ^ sr[14] ^ sr[13];
                    sr = {sr[13:0], o[b]};
                end
            nx = o;
            if (scr_off && !ins_off && n % 4 == 3 && o == last)
                o = (n % 128 == 127) ? link_pkg::CH_A : link_pkg::CH_F;
            if (n % 4 == 3)
                last = nx;
            v = {2'b00, o} ^ {10{enc_invert}};
            if (enc_mirror)
                v = {<<{v}};
            exp_q.push_back(v);
            n++;
            nx = 8'($urandom);
            if (n % 4 == 3)
                nx = (n < 4) ? 8'h55 : ($urandom % 2 ? last : nx);
            data_in <= nx;
            {enc_invert, enc_mirror} <= 2'($urandom);
        end
    end

    // Monitor compares characters chosen outside code sync
    always @(posedge clock)
    begin
        ph_q <= phase;
        if (rstn && ph_q != 2'h0)
            check("lane_data", lane_data, exp_q.size() ? exp_q.pop_front() : 10'h3FF);
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(43335));
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        check("lane_on", {9'h000, lane_on}, 10'h001);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clock);
            prv = lane_data;
            check("comma", lane_data, lane_data[9] ? 10'h305 : 10'h0FA);
            @(posedge clock);
            check("disparity", lane_data, ~prv);
        end
        enc_bypass <= 1'b1;
        for (int r = 0; r < 3; r++)
        begin
            resync <= 1'b1;
            link_reset <= (r == 2);
            wait_ph(2'h0);
            scr_off <= (r != 2);
            ins_off <= (r == 1);
            push_ilas(r == 2);
            @(posedge clock);
            resync <= 1'b0;
            link_reset <= 1'b0;
            wait_ph(2'h1);
            wait_ph(2'h2);
            repeat (300) @(posedge clock);
        end
        lane_disable <= 1'b1;
        repeat (2) @(posedge clock);
        check("lane_on", {9'h000, lane_on}, 10'h000);
        stop_test();
    end
endmodule : tb_tx_link
